// [hw/seq_consts.svh]
// offsets, field positions, reset values and timing counts of the sequencer
// assumes a 40 MHz ref_clk and 32-bit apb with byte addresses
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define OFF_CFG 8'h00
`define OFF_STAT 8'h04
`define OFF_IST 8'h08
`define OFF_IMASK 8'h0C
`define BASE_DATA 3'h1
`define BASE_ALIM 3'h2
`define BASE_OLIM 3'h3
`define CFG_FAST_BIT 4
`define CFG_STBY_BIT 6
`define CFG_RST 8'h00
`define LIM_RST 8'h7F
`define NUM_CH 3'h7
`define NUM_OLIM 3'h4
`define NUM_DIODE 3'h3
`define CH_LAST 3'h6
`define CH_THERM0 3'h4
`define DATA_ONES 11'h07FF
`define DATA_ONES_NARROW 11'h00FF
`define EV_CONV 0
`define EV_FAULT 1
`define EV_TOUT 2
`define TOUT_MS 25
`define CLK_KHZ 40000
`define TOUT_CYC (`TOUT_MS * `CLK_KHZ)
`endif

// [hw/seq_pkg.sv]
// types of the temperature conversion sequencer
// assumes seq_consts.svh is included by the design file
package seq_pkg;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT} seq_e;
   typedef struct packed {
      logic start;
      logic abort;
      logic [2:0] ch;
      logic vref_on;
   } adc_req_s;
   typedef struct packed {
      logic done;
      logic diode_open;
      logic [10:0] result;
   } adc_rsp_s;
   typedef struct packed {
      seq_e st;
      logic [2:0] ch;
      logic [2:0] other;
      logic [6:0][10:0] data;
      logic [6:0][7:0] alim;
      logic [3:0][7:0] olim;
      logic [7:0] cfg;
      logic [2:0] fault;
      logic [2:0] ist;
      logic [2:0] imask;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      logic start_seen;
      logic [19:0] tcnt;
      logic alert_n;
      logic shut_n;
      logic tout;
      adc_req_s req;
   } st_s;
endpackage : seq_pkg

// [hw/temp_seq.sv]
// conversion sequencer, alarm compare and apb register file
// assumes an adc front end on ref_clk and raw smbus pins from outside
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "seq_consts.svh"

// Overview of operation
// - the shutdown output pulls low while channel 1, 4, 5 or 6 is above its shutdown limit.
// - the alert output pulls low while any channel is above its alert limit.
// - every channel has an alert limit, and channels 1, 4, 5 and 6 also a shutdown limit.
// - by default channels convert in the order diode 1, 2, 3, local, thermistor 1, 2, 3.
// - each finished conversion is written into that channel's own data register.
// - config bit 4 set to one selects the fast channel 1 mode.
// - in fast mode channel 1 is converted before every other channel in turn.
// - the standby bit set to one stops all conversions.
// - in standby all registers are kept and the bus side keeps answering.
// - in standby the bus timeout is armed only after a start condition is seen.
// - standby during a conversion aborts it with no write, old data staying readable.
// - the thermistor reference is on for thermistor conversions and off for diodes.
// - thermistor results are kept as a fraction of the reference, not in degrees.
// - channel 1 keeps 11 bits of 0.125 degree, the other diodes and local 8 bits of 1 degree, thermistors 8 bits.
// - an open diode sets its fault bit and stores all ones, raising no alarm.
module temp_seq #(
   parameter int unsigned TIMEOUT_CYCLES = `TOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output seq_pkg::adc_req_s adc_req,
   input wire seq_pkg::adc_rsp_s adc_rsp,
   input wire logic smb_scl_in,
   input wire logic smb_sda_in,
   output logic smb_if_reset,
   output logic irq,
   output logic alert_od_o,
   output logic alert_od_oe_n,
   output logic thermal_shutdown_out_o,
   output logic thermal_shutdown_out_oe_n
);
   seq_pkg::st_s q;
   seq_pkg::st_s d;
   logic [6:0][7:0] val;
   logic [6:0] ahit;
   logic [3:0] ohit;
   logic [6:0] f7;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `OFF_CFG) || (a == `OFF_STAT) || (a == `OFF_IST) ||
         (a == `OFF_IMASK) || (a[1:0] == 2'h0 &&
         (((a[7:5] == `BASE_DATA || a[7:5] == `BASE_ALIM) && a[4:2] < `NUM_CH) ||
         (a[7:5] == `BASE_OLIM && a[4:2] < `NUM_OLIM)));
   endfunction : addr_ok

   assign f7 = {4'h0, q.fault};

   // ch1 compares its top 8 bits; faulted diodes never alarm
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_alert
         if (gi == 0) begin : g_wide
            assign val[gi] = q.data[gi][10:3];
         end else begin : g_narrow
            assign val[gi] = q.data[gi][7:0];
         end
         assign ahit[gi] = !f7[gi] && (val[gi] > q.alim[gi]);
      end
      for (gi = 0; gi < 4; gi++) begin : g_shut
         localparam int CH = (gi == 0) ? 0 : gi + 2;
         assign ohit[gi] = !f7[CH] && (val[CH] > q.olim[gi]);
      end
   endgenerate

   always_comb begin
      logic stby;
      logic fast;
      logic wr;
      logic start_c;
      logic stop_c;
      logic armed;
      logic [2:0] ev;
      logic [2:0] clr;
      stby = q.cfg[`CFG_STBY_BIT];
      fast = q.cfg[`CFG_FAST_BIT];
      wr = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      armed = 1'b0;
      ev = 3'h0;
      clr = 3'h0;
      d = q;
      d.req.start = 1'b0;
      d.req.abort = 1'b0;
      d.tout = 1'b0;

      case (q.st)
         seq_pkg::SEQ_IDLE: begin
            if (!stby) begin
               d.req.start = 1'b1;
               d.st = seq_pkg::SEQ_WAIT;
            end
         end
         seq_pkg::SEQ_WAIT: begin
            if (stby) begin
               // result dropped, stored data untouched
               d.req.abort = 1'b1;
               d.st = seq_pkg::SEQ_IDLE;
            end else if (adc_rsp.done) begin
               ev[`EV_CONV] = 1'b1;
               if (q.ch < `NUM_DIODE && adc_rsp.diode_open) begin
                  // all ones at the channel's own width
                  if (q.ch == 3'h0) begin
                     d.data[q.ch] = `DATA_ONES;
                  end else begin
                     d.data[q.ch] = `DATA_ONES_NARROW;
                  end
                  d.fault[q.ch[1:0]] = 1'b1;
                  ev[`EV_FAULT] = 1'b1;
               end else begin
                  // thermistor codes are ratios of vref, kept as is
                  if (q.ch == 3'h0) begin
                     d.data[q.ch] = adc_rsp.result;
                  end else begin
                     d.data[q.ch] = {3'h0, adc_rsp.result[10:3]};
                  end
                  if (q.ch < `NUM_DIODE) begin
                     d.fault[q.ch[1:0]] = 1'b0;
                  end
               end
               if (fast) begin
                  if (q.ch != 3'h0) begin
                     d.ch = 3'h0;
                  end else begin
                     d.ch = q.other;
                     d.other = (q.other == `CH_LAST) ? 3'h1 : q.other + 3'h1;
                  end
               end else begin
                  d.ch = (q.ch == `CH_LAST) ? 3'h0 : q.ch + 3'h1;
               end
               d.st = seq_pkg::SEQ_IDLE;
            end
         end
         default: begin
            d.st = seq_pkg::SEQ_IDLE;
         end
      endcase
      d.req.ch = d.ch;
      d.req.vref_on = (d.st == seq_pkg::SEQ_WAIT) && (d.ch >= `CH_THERM0);

      // pins: three stages, a level counts once stages two and three agree
      d.scl_s = {q.scl_s[1:0], smb_scl_in};
      d.sda_s = {q.sda_s[1:0], smb_sda_in};
      if (q.scl_s[2] == q.scl_s[1]) begin
         d.scl_f = q.scl_s[2];
      end
      if (q.sda_s[2] == q.sda_s[1]) begin
         d.sda_f = q.sda_s[2];
      end
      start_c = q.scl_f && q.sda_f && !d.sda_f;
      stop_c = q.scl_f && !q.sda_f && d.sda_f;
      if (!stby) begin
         d.start_seen = 1'b0;
      end else if (start_c) begin
         d.start_seen = 1'b1;
      end else if (stop_c) begin
         d.start_seen = 1'b0;
      end
      armed = !stby || q.start_seen;
      if (!armed || q.scl_f) begin
         d.tcnt = 20'h0;
      end else if (d.tcnt == 20'(TIMEOUT_CYCLES - 1)) begin
         d.tcnt = 20'h0;
         d.tout = 1'b1;
         ev[`EV_TOUT] = 1'b1;
      end else begin
         d.tcnt = q.tcnt + 20'h1;
      end

      // apb: one wait state so read data comes from a flop
      d.ack = 1'b0;
      if (psel && penable && !q.ack) begin
         d.ack = 1'b1;
         d.err = !addr_ok(paddr);
         d.rdata = 32'h0;
         case (paddr[7:5])
            `BASE_DATA: d.rdata = {21'h0, q.data[paddr[4:2]]};
            `BASE_ALIM: d.rdata = {24'h0, q.alim[paddr[4:2]]};
            `BASE_OLIM: d.rdata = {24'h0, q.olim[paddr[3:2]]};
            default: begin
               case (paddr)
                  `OFF_CFG: d.rdata = {24'h0, q.cfg};
                  `OFF_STAT: d.rdata = {28'h0, q.st == seq_pkg::SEQ_WAIT, q.fault};
                  `OFF_IST: d.rdata = {29'h0, q.ist};
                  `OFF_IMASK: d.rdata = {29'h0, q.imask};
                  default: d.rdata = 32'h0;
               endcase
            end
         endcase
         // holes in a bank read zero, not a neighbouring register
         if (d.err) begin
            d.rdata = 32'h0;
         end
      end
      wr = psel && penable && q.ack && pwrite && !q.err;
      if (wr) begin
         case (paddr[7:5])
            `BASE_ALIM: d.alim[paddr[4:2]] = pwdata[7:0];
            `BASE_OLIM: d.olim[paddr[3:2]] = pwdata[7:0];
            default: begin
               if (paddr == `OFF_CFG) begin
                  d.cfg = pwdata[7:0];
               end
               if (paddr == `OFF_IST) begin
                  clr = pwdata[2:0];
               end
               if (paddr == `OFF_IMASK) begin
                  d.imask = pwdata[2:0];
               end
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      d.ist = (q.ist & ~clr) | ev;

      d.alert_n = ~|ahit;
      d.shut_n = ~|ohit;

      if (!rst_b) begin
         d = '0;
         d.st = seq_pkg::SEQ_IDLE;
         d.other = 3'h1;
         d.alim = {7{`LIM_RST}};
         d.olim = {4{`LIM_RST}};
         d.cfg = `CFG_RST;
         d.scl_s = 3'h7;
         d.sda_s = 3'h7;
         d.scl_f = 1'b1;
         d.sda_f = 1'b1;
         d.alert_n = 1'b1;
         d.shut_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      q <= d;
   end

   assign prdata = q.rdata;
   assign pready = psel && penable && q.ack;
   assign pslverr = pready && q.err;
   assign adc_req = q.req;
   assign smb_if_reset = q.tout;
   assign irq = |(q.ist & q.imask);
   // open drain: output enable low pulls the pin low
   assign alert_od_o = 1'b0;
   assign alert_od_oe_n = q.alert_n;
   assign thermal_shutdown_out_o = 1'b0;
   assign thermal_shutdown_out_oe_n = q.shut_n;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   logic done_ok;
   assign done_ok = q.st == seq_pkg::SEQ_WAIT && !q.cfg[`CFG_STBY_BIT] && adc_rsp.done;

   AST_SHUTDOWN_LOW: assert property (|ohit |=> !thermal_shutdown_out_oe_n)
      else $error("shutdown output not pulled low");
   AST_ALERT_LOW: assert property (|ahit |=> !alert_od_oe_n)
      else $error("alert output not pulled low");
   AST_ALIM_WR: assert property (pready && pwrite && paddr == 8'h44 |=>
      q.alim[1] == $past(pwdata[7:0])) else $error("alert limit not stored");
   AST_ORDER: assert property (done_ok && !q.cfg[`CFG_FAST_BIT] |=>
      q.ch == (($past(q.ch) == 3'h6) ? 3'h0 : $past(q.ch) + 3'h1))
      else $error("default order broken");
   AST_STORE: assert property (done_ok && q.ch == 3'h3 |=>
      q.data[3][7:0] == $past(adc_rsp.result[10:3])) else $error("result not stored");
   AST_FAST: assert property (done_ok && q.cfg[`CFG_FAST_BIT] && q.ch != 3'h0 |=>
      q.ch == 3'h0 ##1 adc_req.start && adc_req.ch == 3'h0)
      else $error("fast mode did not return to channel 1");
   AST_ABORT: assert property (q.cfg[`CFG_STBY_BIT] && q.st == seq_pkg::SEQ_WAIT |=>
      adc_req.abort && $stable(q.data) ##1 q.st == seq_pkg::SEQ_IDLE)
      else $error("standby did not abort cleanly");
   AST_STOPPED: assert property (q.cfg[`CFG_STBY_BIT] [*2] |-> !adc_req.start)
      else $error("conversion started in standby");
   AST_VREF: assert property (adc_req.start |-> adc_req.vref_on == (adc_req.ch >= 3'h4))
      else $error("reference state wrong");
   AST_FAULT: assert property (done_ok && q.ch == 3'h2 && adc_rsp.diode_open |=>
      q.fault[2] && q.data[2] == 11'h00FF && !ahit[2]) else $error("open diode mishandled");
   AST_WIDE: assert property (done_ok && q.ch == 3'h0 && !adc_rsp.diode_open |=>
      q.data[0] == $past(adc_rsp.result)) else $error("channel 1 result not kept in full");
   AST_STBY_BUS: assert property (q.cfg[`CFG_STBY_BIT] && psel && penable && !q.ack |=>
      pready) else $error("bus not answering in standby");
   AST_ARM: assert property (smb_if_reset |-> $past(!q.cfg[`CFG_STBY_BIT] || q.start_seen))
      else $error("timeout fired while disarmed");
   AST_RST_CFG: assert property ($rose(rst_b) |-> q.cfg == 8'h00)
      else $error("config not cleared by reset");

   COV_FAST: cover property (done_ok && q.cfg[`CFG_FAST_BIT] && q.ch == 3'h6);
   COV_ABORT: cover property (adc_req.abort);
   COV_SHUTDOWN: cover property (!thermal_shutdown_out_oe_n && irq);
endmodule : temp_seq

// [test/adc_model.sv]
// behavioural adc front end answering conversion requests
// assumes start and abort are one-cycle pulses on ref_clk
module adc_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire seq_pkg::adc_req_s adc_req,
   output seq_pkg::adc_rsp_s adc_rsp,
   input wire logic [7:0] lat,
   input wire logic [6:0][10:0] temp,
   input wire logic [6:0] open_ch
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy;
   logic [7:0] cnt;
   logic [2:0] ch;
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         ch <= 3'h0;
         adc_rsp <= '0;
      end else begin
         adc_rsp.done <= 1'b0;
         if (adc_req.abort) begin
            busy <= 1'b0;
         end else if (adc_req.start) begin
            busy <= 1'b1;
            cnt <= lat;
            ch <= adc_req.ch;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            adc_rsp.done <= 1'b1;
            adc_rsp.diode_open <= open_ch[ch];
            adc_rsp.result <= open_ch[ch] ? 11'h0155 : temp[ch];
         end else begin
            // stale result toggles so it never passes for fresh data
            adc_rsp.result <= ~adc_rsp.result;
            if (busy) begin
               cnt <= cnt - 8'h01;
            end
         end
      end
   end
endmodule : adc_model

// [test/temp_seq_tb_top.sv]
// self-checking bench of the conversion sequencer
// assumes adc_model on the far side and apb master tasks here
module temp_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] a;
      logic w;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } row_s;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic scl = 1'b1;
   logic sda = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [7:0] lat = 8'h02;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, irq, a_o, a_oe_n, t_o, t_oe_n, srst;
   seq_pkg::adc_req_s adc_req;
   seq_pkg::adc_rsp_s adc_rsp;
   logic [6:0][10:0] temp = {11'h0230, 11'h0228, 11'h0220, 11'h0218, 11'h0210, 11'h0208, 11'h0200};
   logic [6:0][10:0] base;
   logic [6:0] open_ch = 7'h00;
   logic [2:0] q[$];
   logic [2:0] c;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_abort = 0;
   int n_srst = 0;
   row_s rows [9] = '{'{8'h00, 1'b0, '0, '0, 1'b0}, '{8'h40, 1'b0, '0, 32'h7F, 1'b0},
      '{8'h58, 1'b0, '0, 32'h7F, 1'b0}, '{8'h60, 1'b0, '0, 32'h7F, 1'b0},
      '{8'h6C, 1'b0, '0, 32'h7F, 1'b0}, '{8'h0C, 1'b1, 32'h7, '0, 1'b0},
      '{8'h0C, 1'b0, '0, 32'h7, 1'b0}, '{8'h70, 1'b1, 32'h5, '0, 1'b1},
      '{8'h70, 1'b0, '0, '0, 1'b1}};
   always #12.5 ref_clk = ~ref_clk;
   temp_seq #(.TIMEOUT_CYCLES(50)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_req(adc_req), .adc_rsp(adc_rsp),
      .smb_scl_in(scl), .smb_sda_in(sda), .smb_if_reset(srst), .irq(irq),
      .alert_od_o(a_o), .alert_od_oe_n(a_oe_n), .thermal_shutdown_out_o(t_o),
      .thermal_shutdown_out_oe_n(t_oe_n));
   adc_model adc (.ref_clk(ref_clk), .rst_b(rst_b), .adc_req(adc_req), .adc_rsp(adc_rsp),
      .lat(lat), .temp(temp), .open_ch(open_ch));
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         n_mismatch++;
         $display("FAIL %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task finish_test;
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   // pulses are sampled mid-cycle, away from the launching edge
   always @(negedge ref_clk) begin
      if (adc_req.start === 1'b1) begin
         q.push_back(adc_req.ch);
         chk(32'(adc_req.vref_on), 32'(adc_req.ch >= 3'h4));
      end
      if (adc_req.abort === 1'b1) n_abort++;
      if (srst === 1'b1) n_srst++;
   end
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // read at the edge itself, before that edge updates the slave
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
      if (n >= 20) chk(32'h1, 32'h0);
   endtask : apb
   task rdc(input logic [7:0] a, input logic [31:0] x);
      apb(a, 1'b0, '0);
      chk(rd, x);
   endtask : rdc
   task waitq(input int n);
      int k;
      k = 0;
      while (q.size() < n && k < 5000) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 5000) chk(32'h1, 32'h0);
   endtask : waitq
   // pins are checked half a cycle after the fourth edge after the limit change lands
   task pins(input logic [4:0] x);
      cyc(3);
      @(negedge ref_clk);
      chk(32'({irq, a_o, t_o, a_oe_n, t_oe_n}), 32'(x));
      @(posedge ref_clk);
   endtask : pins
   initial begin
      cyc(10);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].x);
         chk(32'(er), 32'(rows[i].e));
      end
      q.delete();
      waitq(15);
      for (int k = 0; k < 14; k++) chk(32'(q[k + 1]), 32'(q[k] == 3'h6 ? 3'h0 : q[k] + 3'h1));
      for (int i = 0; i < 7; i++) rdc(8'h20 + 8'(4 * i), i == 0 ? 32'h200 : 32'h40 + 32'(i));
      apb(8'h44, 1'b1, 32'h40);
      apb(8'h64, 1'b1, 32'h43);
      pins(5'b10001);
      apb(8'h64, 1'b1, 32'h42);
      pins(5'b10000);
      apb(8'h44, 1'b1, 32'h7F);
      apb(8'h64, 1'b1, 32'h7F);
      pins(5'b10011);
      apb(8'h0C, 1'b1, 32'h2);
      apb(8'h08, 1'b1, 32'h7);
      open_ch <= 7'h04;
      q.delete();
      waitq(8);
      rdc(8'h28, 32'hFF);
      apb(8'h04, 1'b0, '0);
      chk(rd & 32'h7, 32'h4);
      pins(5'b10011);
      open_ch <= 7'h00;
      q.delete();
      waitq(8);
      apb(8'h08, 1'b1, 32'h2);
      pins(5'b00011);
      apb(8'h00, 1'b1, 32'h10);
      q.delete();
      waitq(3);
      q.delete();
      waitq(14);
      for (int k = 0; k < 12; k++) begin
         if (q[k] == 3'h0) chk(32'(q[k + 1] != 3'h0), 32'h1);
         else begin
            chk(32'(q[k + 1]), 32'h0);
            chk(32'(q[k + 2]), 32'(q[k] == 3'h6 ? 3'h1 : q[k] + 3'h1));
         end
      end
      apb(8'h00, 1'b1, 32'h0);
      lat <= 8'h28;
      q.delete();
      waitq(2);
      c = q[1];
      base = temp;
      temp <= {7{11'h0600}};
      apb(8'h00, 1'b1, 32'h40);
      cyc(5);
      chk(32'(n_abort), 32'h1);
      q.delete();
      cyc(200);
      chk(32'(q.size()), 32'h0);
      rdc(8'h20 + 8'(4 * c), c == 3'h0 ? 32'h200 : 32'h40 + 32'(c));
      rdc(8'h00, 32'h40);
      scl <= 1'b0;
      cyc(80);
      chk(32'(n_srst), 32'h0);
      scl <= 1'b1;
      cyc(8);
      sda <= 1'b0;
      // a few 200 ns link clocks inside the frame, then scl held low
      repeat (4) begin
         cyc(4);
         scl <= 1'b0;
         cyc(4);
         scl <= 1'b1;
      end
      scl <= 1'b0;
      cyc(80);
      chk(32'(n_srst), 32'h1);
      scl <= 1'b1;
      cyc(4);
      sda <= 1'b1;
      temp <= base;
      lat <= 8'h02;
      apb(8'h00, 1'b1, 32'h50);
      rst_b <= 1'b0;
      cyc(10);
      rst_b <= 1'b1;
      q.delete();
      @(posedge ref_clk);
      rdc(8'h00, 32'h0);
      waitq(2);
      chk(32'(q[0]), 32'h0);
      chk(32'(q[1]), 32'h1);
      finish_test();
   end
   initial begin
      cyc(40000);
      n_mismatch++;
      finish_test();
   end
endmodule : temp_seq_tb_top
